// ---- common/ccd_pkg.sv ----
// constants, field layout and types of the output-pair divider block
// assumes a 32-bit APB register slave, one word per register index
package ccd_pkg;

  // register indices; byte address is four times the index
  localparam int CCD_IDX_W = 10;
  localparam int CCD_ADDR_W = 12;
  localparam logic [9:0] CCD_IDX_D1_ROUTE = 10'h195;
  localparam logic [9:0] CCD_IDX_D2_COUNTS = 10'h196;
  localparam logic [9:0] CCD_IDX_D2_CTRL = 10'h197;
  localparam logic [9:0] CCD_IDX_D2_ROUTE = 10'h198;
  localparam logic [9:0] CCD_IDX_STATUS = 10'h199;
  localparam logic [9:0] CCD_IDX_IN_SEL = 10'h1E1;

  // field positions
  localparam int CCD_LOW_LSB = 4;
  localparam int CCD_HIGH_LSB = 0;
  localparam int CCD_BIT_BYPASS = 7;
  localparam int CCD_BIT_NOSYNC = 6;
  localparam int CCD_BIT_FORCE = 5;
  localparam int CCD_BIT_START = 4;
  localparam int CCD_PHASE_LSB = 0;
  localparam int CCD_BIT_DIRECT = 1;
  localparam int CCD_BIT_DUTY_CORRECT_DISABLE = 0;
  localparam int CCD_BIT_SEL_OSC = 1;
  localparam int CCD_BIT_SEL_BYP = 0;

  // reset values
  localparam logic [7:0] CCD_RST_COUNTS = 8'h00;
  localparam logic [7:0] CCD_RST_CTRL = 8'h00;
  localparam logic [1:0] CCD_RST_ROUTE = 2'h0;
  localparam logic [1:0] CCD_RST_IN_SEL = 2'h0;

  // input-select codes
  localparam logic [1:0] CCD_SEL_EXT = 2'h0;
  localparam logic [1:0] CCD_SEL_BYP = 2'h1;
  localparam logic [1:0] CCD_SEL_OSC = 2'h2;

  typedef struct packed {
    logic [3:0] lowCnt;
    logic [3:0] highCnt;
    logic bypass;
    logic noSync;
    logic forceHigh;
    logic startHigh;
    logic [3:0] phase;
  } ccd_div_cfg_t;

  typedef struct packed {
    logic direct;
    logic duty_correct_disable;
  } ccd_route_t;

  typedef enum logic [3:0] {
    CCD_HOLD = 4'h1,
    CCD_DELAY = 4'h2,
    CCD_LOW = 4'h4,
    CCD_HIGH = 4'h8
  } ccd_state_t;

endpackage : ccd_pkg

// ---- design/ccd_channel_clock_divider.sv ----
// output-pair divider block: APB registers, input select, pair routing
// assumes oscillator, external and upstream-divided clocks arrive as
// levels synchronous to mclk; one zero-wait APB slave
`timescale 1ns/1ps
`default_nettype none
module ccd_channel_clock_divider
  import ccd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CCD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscClk,
  input wire logic extClk,
  input wire logic upDivClk,
  input wire logic div1Clk,
  input wire logic syncReq,
  output logic upDivSrc,
  output logic pair1OutA,
  output logic pair1OutB,
  output logic pair2OutA,
  output logic pair2OutB,
  output logic dutyCorrect1,
  output logic dutyCorrect2
);

  // register storage
  ccd_route_t d1Route;
  ccd_route_t d2Route;
  logic [7:0] d2Counts;
  logic [7:0] d2Ctrl;
  logic [1:0] inSel;

  // address decode
  wire [CCD_IDX_W-1:0] regIdx = paddr[CCD_ADDR_W-1:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire hitD1Route = aligned & (regIdx == CCD_IDX_D1_ROUTE);
  wire hitD2Counts = aligned & (regIdx == CCD_IDX_D2_COUNTS);
  wire hitD2Ctrl = aligned & (regIdx == CCD_IDX_D2_CTRL);
  wire hitD2Route = aligned & (regIdx == CCD_IDX_D2_ROUTE);
  wire hitStatus = aligned & (regIdx == CCD_IDX_STATUS);
  wire hitInSel = aligned & (regIdx == CCD_IDX_IN_SEL);
  wire anyHit = hitD1Route | hitD2Counts | hitD2Ctrl | hitD2Route |
    hitStatus | hitInSel;
  wire accessPhase = psel & penable;
  wire setupPhase = psel & ~penable;
  wire wrByte = accessPhase & pwrite & anyHit & pstrb[0];
  wire [7:0] wrData = pwdata[7:0];

  // divider state seen by software
  logic div2Level;
  logic div2Running;
  wire [7:0] statusWord = {4'h0, pair2OutA, pair1OutA, div2Level,
    div2Running};

  wire [7:0] rdD1Route = {6'h00, d1Route.direct, d1Route.duty_correct_disable};
  wire [7:0] rdD2Route = {6'h00, d2Route.direct, d2Route.duty_correct_disable};
  wire [7:0] rdInSel = {6'h00, inSel};
  wire [7:0] rdByte = hitD1Route ? rdD1Route :
    hitD2Counts ? d2Counts :
    hitD2Ctrl ? d2Ctrl :
    hitD2Route ? rdD2Route :
    hitStatus ? statusWord :
    hitInSel ? rdInSel : 8'h00;

  // zero-wait slave; unmapped or misaligned access answers with error
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~anyHit;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (setupPhase) begin
      prdata <= {24'h000000, rdByte};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      d1Route <= CCD_RST_ROUTE;
      d2Route <= CCD_RST_ROUTE;
      d2Counts <= CCD_RST_COUNTS;
      d2Ctrl <= CCD_RST_CTRL;
      inSel <= CCD_RST_IN_SEL;
    end else if (wrByte) begin
      if (hitD1Route) begin
        d1Route <= {wrData[CCD_BIT_DIRECT], wrData[CCD_BIT_DUTY_CORRECT_DISABLE]};
      end
      if (hitD2Counts) begin
        d2Counts <= wrData;
      end
      if (hitD2Ctrl) begin
        d2Ctrl <= wrData;
      end
      if (hitD2Route) begin
        d2Route <= {wrData[CCD_BIT_DIRECT], wrData[CCD_BIT_DUTY_CORRECT_DISABLE]};
      end
      if (hitInSel) begin
        inSel <= wrData[1:0];
      end
    end
  end

  // field unpacking for the second-pair divider
  wire ccd_div_cfg_t div2Cfg = '{
    lowCnt: d2Counts[CCD_LOW_LSB +: 4],
    highCnt: d2Counts[CCD_HIGH_LSB +: 4],
    bypass: d2Ctrl[CCD_BIT_BYPASS],
    noSync: d2Ctrl[CCD_BIT_NOSYNC],
    forceHigh: d2Ctrl[CCD_BIT_FORCE],
    startHigh: d2Ctrl[CCD_BIT_START],
    phase: d2Ctrl[CCD_PHASE_LSB +: 4]
  };

  // input select: bypass of the upstream divider wins over the
  // oscillator choice, so code 11b behaves as 01b
  wire upBypass = inSel[CCD_BIT_SEL_BYP];
  wire oscChosen = inSel[CCD_BIT_SEL_OSC] & ~upBypass;
  wire next_upDivSrc = oscChosen ? oscClk : extClk;
  wire distClk = upBypass ? extClk : upDivClk;

  ccd_divider u_div2 (
    .mclk(mclk),
    .rst_n(rst_n),
    .inClk(distClk),
    .syncReq(syncReq),
    .cfg(div2Cfg),
    .outLevel(div2Level),
    .running(div2Running)
  );

  // pair routing: direct route replaces the divider only for 10b or 00b
  wire d1Osc = d1Route.direct & (inSel == CCD_SEL_OSC);
  wire d1Ext = d1Route.direct & (inSel == CCD_SEL_EXT);
  wire d2Osc = d2Route.direct & (inSel == CCD_SEL_OSC);
  wire d2Ext = d2Route.direct & (inSel == CCD_SEL_EXT);
  wire next_pair1 = d1Osc ? oscClk : d1Ext ? extClk : div1Clk;
  wire next_pair2 = d2Osc ? oscClk : d2Ext ? extClk : div2Level;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      upDivSrc <= 1'b0;
      pair1OutA <= 1'b0;
      pair1OutB <= 1'b0;
      pair2OutA <= 1'b0;
      pair2OutB <= 1'b0;
    end else begin
      upDivSrc <= next_upDivSrc;
      pair1OutA <= next_pair1;
      pair1OutB <= next_pair1;
      pair2OutA <= next_pair2;
      pair2OutB <= next_pair2;
    end
  end

  // duty correction stage enables per pair
  assign dutyCorrect1 = ~d1Route.duty_correct_disable;
  assign dutyCorrect2 = ~d2Route.duty_correct_disable;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  pair2_osc_a: assert property (d2Osc |=>
    pair2OutA == $past(oscClk) && pair2OutB == pair2OutA)
    else $error("pair two not fed from oscillator");
  pair2_ext_a: assert property (d2Ext |=>
    pair2OutA == $past(extClk)) else $error("pair two not fed from ext");
  pair2_div_a: assert property ((!d2Osc && !d2Ext) |=>
    pair2OutA == $past(div2Level)) else $error("pair two not divided");
  pair1_route_a: assert property (d1Osc |=>
    pair1OutA == $past(oscClk)) else $error("pair one not fed from osc");
  pair1_div_a: assert property ((!d1Osc && !d1Ext) |=>
    pair1OutB == $past(div1Clk)) else $error("pair one not divided");
  duty_enable_a: assert property ((wrByte && hitD2Route) |=>
    dutyCorrect2 == !$past(pwdata[CCD_BIT_DUTY_CORRECT_DISABLE]))
    else $error("duty enable wrong");
  up_select_a: assert property (oscChosen |=>
    upDivSrc == $past(oscClk)) else $error("oscillator not selected");
  up_bypass_a: assert property (upBypass |=>
    upDivSrc == $past(extClk)) else $error("oscillator chosen in bypass");
  force_bypass_a: assert property ((div2Cfg.bypass && !d2Osc &&
    !d2Ext) ##1 (!d2Osc && !d2Ext) |=> pair2OutA == $past(distClk, 2))
    else $error("force acts during bypass");
  unmapped_err_a: assert property ((accessPhase && !anyHit) |-> pslverr
    ##1 (d2Counts == $past(d2Counts) && d2Ctrl == $past(d2Ctrl)))
    else $error("unmapped access not refused");
  write_ctrl_a: assert property ((wrByte && hitD2Ctrl) |=>
    d2Ctrl == $past(pwdata[7:0])) else $error("control write lost");

  // both pins of a pair, and the no-effect select code
  pair1_ext_a: assert property (
    d1Ext
    |=> pair1OutA == $past(extClk) && pair1OutB == $past(extClk))
    else $error("pair one not fed from ext");
  pair1_osc_b_a: assert property (
    d1Osc
    |=> pair1OutB == $past(oscClk))
    else $error("pair one b not fed from osc");
  pair1_plain_a: assert property (
    (!d1Osc && !d1Ext)
    |=> pair1OutA == $past(div1Clk))
    else $error("pair one a not divided");
  pair1_keep_a: assert property (
    (d1Route.direct && inSel == CCD_SEL_BYP)
    |=> pair1OutA == $past(div1Clk))
    else $error("pair one routed on no-effect code");
  pair2_keep_a: assert property (
    (d2Route.direct && inSel == CCD_SEL_BYP)
    |=> pair2OutA == $past(div2Level))
    else $error("pair two routed on no-effect code");
  pair2_osc_b_a: assert property (
    d2Osc
    |=> pair2OutB == $past(oscClk))
    else $error("pair two b not fed from osc");
  pair2_ext_b_a: assert property (
    d2Ext
    |=> pair2OutB == $past(extClk))
    else $error("pair two b not fed from ext");
  pair2_div_b_a: assert property (
    (!d2Osc && !d2Ext)
    |=> pair2OutB == $past(div2Level))
    else $error("pair two b not divided");
  up_ext_a: assert property (
    (!inSel[CCD_BIT_SEL_OSC])
    |=> upDivSrc == $past(extClk))
    else $error("external clock not selected");
  up_osc_refused_a: assert property (
    (inSel == 2'h3)
    |=> upDivSrc == $past(extClk))
    else $error("oscillator taken while bypassed");

  // register writes
  duty1_write_a: assert property (
    (wrByte && hitD1Route)
    |=> dutyCorrect1 == !$past(pwdata[CCD_BIT_DUTY_CORRECT_DISABLE]))
    else $error("pair one duty enable wrong");
  route1_write_a: assert property (
    (wrByte && hitD1Route)
    |=> d1Route.direct == $past(pwdata[CCD_BIT_DIRECT]))
    else $error("pair one route write lost");
  route2_write_a: assert property (
    (wrByte && hitD2Route)
    |=> d2Route.direct == $past(pwdata[CCD_BIT_DIRECT]))
    else $error("pair two route write lost");
  counts_write_a: assert property (
    (wrByte && hitD2Counts)
    |=> d2Counts == $past(pwdata[7:0]))
    else $error("count write lost");
  insel_write_a: assert property (
    (wrByte && hitInSel)
    |=> inSel == $past(pwdata[1:0]))
    else $error("input select write lost");
  strobe_gate_a: assert property (
    (accessPhase && pwrite && !pstrb[0])
    |=> d2Counts == $past(d2Counts) && d2Ctrl == $past(d2Ctrl) &&
    inSel == $past(inSel))
    else $error("write without strobe landed");
  status_ro_a: assert property (
    (accessPhase && pwrite && hitStatus)
    |=> d2Counts == $past(d2Counts) && d2Ctrl == $past(d2Ctrl))
    else $error("status write changed a register");

  // register reads
  read_ctrl_a: assert property (
    (setupPhase && hitD2Ctrl)
    |=> prdata == {24'h000000, $past(d2Ctrl)})
    else $error("control read wrong");
  read_counts_a: assert property (
    (setupPhase && hitD2Counts)
    |=> prdata == {24'h000000, $past(d2Counts)})
    else $error("count read wrong");
  read_insel_a: assert property (
    (setupPhase && hitInSel)
    |=> prdata == {24'h000000, 6'h00, $past(inSel)})
    else $error("input select read wrong");
  read_status_a: assert property (
    (setupPhase && hitStatus)
    |=> prdata[1:0] == {$past(div2Level), $past(div2Running)})
    else $error("status read wrong");
  read_unmapped_a: assert property (
    (setupPhase && !anyHit)
    |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");

endmodule : ccd_channel_clock_divider
`default_nettype wire

// ---- design/ccd_divider.sv ----
// one output-pair divider counting rising edges of a sampled input clock
// assumes inClk is a level synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module ccd_divider
  import ccd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic inClk,
  input wire logic syncReq,
  input wire ccd_div_cfg_t cfg,
  output logic outLevel,
  output logic running
);

  ccd_state_t state;
  ccd_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic inPrev;
  logic next_level;

  wire rise = inClk & ~inPrev;
  wire syncHold = (syncReq & ~cfg.noSync) | cfg.bypass;
  wire forceOn = ~cfg.bypass & cfg.noSync & syncReq;
  wire ccd_state_t startState = cfg.startHigh ? CCD_HIGH : CCD_LOW;
  wire phaseDone = (cnt == cfg.phase - 4'h1);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      CCD_HOLD: begin
        next_cnt = 4'h0;
        if (!syncHold) begin
          next_state = (cfg.phase == 4'h0) ? startState : CCD_DELAY;
        end
      end
      CCD_DELAY: begin
        if (rise) begin
          next_cnt = cnt + 4'h1;
          if (phaseDone) begin
            next_state = startState;
            next_cnt = 4'h0;
          end
        end
      end
      CCD_LOW: begin
        if (rise) begin
          next_cnt = cnt + 4'h1;
          if (cnt == cfg.lowCnt) begin
            next_state = CCD_HIGH;
            next_cnt = 4'h0;
          end
        end
      end
      CCD_HIGH: begin
        if (rise) begin
          next_cnt = cnt + 4'h1;
          if (cnt == cfg.highCnt) begin
            next_state = CCD_LOW;
            next_cnt = 4'h0;
          end
        end
      end
      default: begin
        next_state = CCD_HOLD;
        next_cnt = 4'h0;
      end
    endcase
    if (syncHold) begin
      next_state = CCD_HOLD;
      next_cnt = 4'h0;
    end
  end

  // output follows the next state so it lines up with the state register
  always_comb begin
    next_level = (next_state == CCD_HIGH) |
      (((next_state == CCD_HOLD) | (next_state == CCD_DELAY)) &
       cfg.startHigh);
    if (cfg.bypass) begin
      next_level = inClk;
    end else if (forceOn) begin
      next_level = cfg.forceHigh;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= CCD_HOLD;
      cnt <= 4'h0;
      inPrev <= 1'b0;
      outLevel <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      inPrev <= inClk;
      outLevel <= next_level;
    end
  end

  assign running = (state == CCD_LOW) | (state == CCD_HIGH);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  bypass_pass_a: assert property (cfg.bypass |=>
    (outLevel == $past(inClk)) && state == CCD_HOLD)
    else $error("bypass does not pass input clock");
  sync_hold_a: assert property ((syncReq && !cfg.noSync) |=>
    state == CCD_HOLD) else $error("divider ignores chip sync");
  force_level_a: assert property (forceOn |=>
    outLevel == $past(cfg.forceHigh)) else $error("force level wrong");
  low_end_a: assert property ((state == CCD_LOW && rise &&
    cnt == cfg.lowCnt && !syncHold) |=> state == CCD_HIGH && cnt == 4'h0)
    else $error("low phase length wrong");
  high_end_a: assert property ((state == CCD_HIGH && rise &&
    cnt == cfg.highCnt && !syncHold) |=> state == CCD_LOW)
    else $error("high phase length wrong");
  start_level_a: assert property ((state == CCD_HOLD && !syncHold &&
    cfg.phase == 4'h0 && !forceOn) |=> outLevel == $past(cfg.startHigh))
    else $error("start level wrong");

endmodule : ccd_divider
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the output-pair divider block over APB
// assumes ccd_pkg and ccd_channel_clock_divider are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ccd_pkg::*;
;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic oscClk, extClk, upDivClk, div1Clk, syncReq, upDivSrc, er;
  logic pair1OutA, pair1OutB, pair2OutA, pair2OutB;
  logic dutyCorrect1, dutyCorrect2;
  int n_mismatch, samples_checked, cyc, phCnt, hi, lo, t0, t3;
  int p1Hi[4] = '{4, 6, 3, 6};
  int p2Hi[4] = '{4, 8, 3, 8};
  int srcHi[4] = '{4, 4, 3, 4};

  ccd_channel_clock_divider DUT (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscClk(oscClk), .extClk(extClk), .upDivClk(upDivClk),
    .div1Clk(div1Clk), .syncReq(syncReq), .upDivSrc(upDivSrc),
    .pair1OutA(pair1OutA), .pair1OutB(pair1OutB), .pair2OutA(pair2OutA),
    .pair2OutB(pair2OutB), .dutyCorrect1(dutyCorrect1),
    .dutyCorrect2(dutyCorrect2));

  always #5 mclk = ~mclk;

  // source clocks of distinct periods: ext 8, osc 6, upstream 10, pair1 12
  always @(posedge mclk) begin
    phCnt <= (phCnt + 1) % 120;
    extClk <= (phCnt % 8) < 4;
    oscClk <= (phCnt % 6) < 3;
    upDivClk <= (phCnt % 10) < 5;
    div1Clk <= (phCnt % 12) < 6;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic check(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got);
    end
  endtask : check

  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [1:0] off, input logic [7:0] d,
                     input logic [3:0] s);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, off};
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    check("apb wait", 1, k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, 2'h0, d, 4'hF);
  endtask : wr

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] ex);
    apb(1'b0, idx, 2'h0, 8'h00, 4'hF);
    check("read data", {24'h0, ex}, rd);
    check("read error", 0, er);
  endtask : rdchk

  function automatic logic pick(input int w);
    return (w == 0) ? pair2OutA : (w == 1) ? pair1OutA : upDivSrc;
  endfunction : pick

  task automatic wait_lvl(input int w, input logic lvl);
    int k;
    k = 0;
    while (pick(w) !== lvl && k < 600) begin
      @(negedge mclk);
      k++;
    end
    check("edge seen", 1, k < 600);
  endtask : wait_lvl

  task automatic measure(input int w);
    wait_lvl(w, 1'b0);
    wait_lvl(w, 1'b1);
    wait_lvl(w, 1'b0);
    wait_lvl(w, 1'b1);
    for (hi = 0; pick(w) === 1'b1 && hi < 600; hi++) @(negedge mclk);
    for (lo = 0; pick(w) === 1'b0 && lo < 600; lo++) @(negedge mclk);
  endtask : measure

  task automatic steady(input logic lvl);
    int bad;
    bad = 0;
    repeat (3) @(negedge mclk);
    repeat (60) begin
      @(negedge mclk);
      if (pair2OutA !== lvl || pair2OutB !== lvl) bad++;
    end
    check("steady level", 0, bad);
  endtask : steady

  task automatic start_delay(output int t);
    syncReq <= 1'b1;
    repeat (20) @(negedge mclk);
    while (phCnt != 119) @(negedge mclk);
    @(posedge mclk);
    syncReq <= 1'b0;
    for (t = 0; pair2OutA !== 1'b1 && t < 600; t++) @(negedge mclk);
  endtask : start_delay

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    mclk = 0;
    rst_n = 0;
    {psel, penable, pwrite, syncReq} = '0;
    {paddr, pwdata, pstrb} = '0;
    {phCnt, cyc, n_mismatch, samples_checked} = '0;
    {oscClk, extClk, upDivClk, div1Clk} = '0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(CCD_IDX_D1_ROUTE, 8'h00);
    rdchk(CCD_IDX_D2_COUNTS, 8'h00);
    rdchk(CCD_IDX_D2_CTRL, 8'h00);
    rdchk(CCD_IDX_D2_ROUTE, 8'h00);
    rdchk(CCD_IDX_IN_SEL, 8'h00);
    check("duty1", 1, dutyCorrect1);
    check("duty2", 1, dutyCorrect2);
    apb(1'b0, 10'h3F0, 2'h0, 8'h00, 4'hF);
    check("unmapped error", 1, er);
    apb(1'b1, CCD_IDX_D2_COUNTS, 2'h1, 8'h77, 4'hF);
    check("misaligned error", 1, er);
    wr(CCD_IDX_D2_COUNTS, 8'h5A);
    apb(1'b1, CCD_IDX_D2_COUNTS, 2'h0, 8'hFF, 4'h0);
    apb(1'b1, CCD_IDX_STATUS, 2'h0, 8'hFF, 4'hF);
    rdchk(CCD_IDX_D2_COUNTS, 8'h5A);
    wr(CCD_IDX_D1_ROUTE, 8'h01);
    wr(CCD_IDX_D2_ROUTE, 8'h01);
    @(negedge mclk);
    check("duty1 off", 0, dutyCorrect1);
    check("duty2 off", 0, dutyCorrect2);
    // routing per input-select code with counts at their minimum
    wr(CCD_IDX_D2_COUNTS, 8'h00);
    wr(CCD_IDX_D1_ROUTE, 8'h02);
    wr(CCD_IDX_D2_ROUTE, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(CCD_IDX_IN_SEL, i[7:0]);
      measure(1);
      check("pair1 high", p1Hi[i], hi);
      measure(0);
      check("pair2 high", p2Hi[i], hi);
      measure(2);
      check("upstream src high", srcHi[i], hi);
    end
    wr(CCD_IDX_D1_ROUTE, 8'h00);
    wr(CCD_IDX_D2_ROUTE, 8'h00);
    measure(1);
    check("pair1 from divider", 6, hi);
    check("pair1 b level", 1, pair1OutB);
    wr(CCD_IDX_IN_SEL, 8'h01);
    wr(CCD_IDX_D2_COUNTS, 8'h21);
    measure(0);
    check("high phase", 16, hi);
    check("low phase", 24, lo);
    wr(CCD_IDX_D2_COUNTS, 8'hF0);
    measure(0);
    check("high min", 8, hi);
    check("low max", 128, lo);
    wr(CCD_IDX_D2_COUNTS, 8'h00);
    wr(CCD_IDX_D2_CTRL, 8'h80);
    measure(0);
    check("bypass high", 4, hi);
    @(posedge mclk);
    syncReq <= 1'b1;
    wr(CCD_IDX_D2_CTRL, 8'hE0);
    measure(0);
    check("bypass beats force", 4, hi);
    wr(CCD_IDX_D2_CTRL, 8'h60);
    steady(1'b1);
    wr(CCD_IDX_D2_CTRL, 8'h40);
    steady(1'b0);
    wr(CCD_IDX_D2_CTRL, 8'h10);
    steady(1'b1);
    apb(1'b0, CCD_IDX_STATUS, 2'h0, 8'h00, 4'hF);
    check("held status", 32'h0A, rd & 32'hFB);
    wr(CCD_IDX_D2_CTRL, 8'h00);
    steady(1'b0);
    wr(CCD_IDX_D2_CTRL, 8'h50);
    apb(1'b0, CCD_IDX_STATUS, 2'h0, 8'h00, 4'hF);
    check("sync ignored", 32'h01, rd & 32'hFB);
    wr(CCD_IDX_D2_CTRL, 8'h00);
    start_delay(t0);
    wr(CCD_IDX_D2_CTRL, 8'h03);
    start_delay(t3);
    check("phase offset", 24, t3 - t0);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
